/* inc/dcrm_pkg.sv */
package dcrm_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SRC = 8'h04;
  localparam logic [7:0] OFF_DST = 8'h08;
  localparam logic [7:0] OFF_CNT = 8'h0C;
  localparam logic [7:0] OFF_RUN = 8'h10;
  localparam logic [7:0] OFF_PEND = 8'h14;
  // Control word fields
  localparam int CTL_RUN = 0;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_BLOCK = 4;
  localparam int CTL_BURST = 5;
  localparam int CTL_SIZE_LO = 6;
  localparam int CTL_SSTEP_LO = 8;
  localparam int CTL_DSTEP_LO = 10;
  localparam int CTL_IE = 12;
  localparam int CTL_ACK_LO = 13;
  localparam int CTL_BUSY = 31;
  localparam int CTRL_W = 17;
  localparam int CNT_W = 24;
  localparam int PEND_BIT = 0;
  // Request modes
  localparam logic [2:0] MODE_SOFT = 3'h0;
  localparam logic [2:0] MODE_EXT = 3'h1;
  localparam logic [2:0] MODE_SER_TX = 3'h2;
  localparam logic [2:0] MODE_SER_RX = 3'h3;
  localparam logic [2:0] MODE_CIP_IN = 3'h4;
  localparam logic [2:0] MODE_CIP_OUT = 3'h5;
  // Item sizes and steps
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [CNT_W-1:0] BYTES_1 = 24'h000001;
  localparam logic [CNT_W-1:0] BYTES_2 = 24'h000002;
  localparam logic [CNT_W-1:0] BYTES_4 = 24'h000004;
  localparam logic [1:0] STEP_INC = 2'h0;
  localparam logic [1:0] STEP_DEC = 2'h1;
  // Transfer targets
  localparam logic [1:0] TGT_MEM = 2'h0;
  localparam logic [1:0] TGT_SER = 2'h1;
  localparam logic [1:0] TGT_CIP = 2'h2;
  // Items per request or group
  localparam logic [2:0] ITEMS_ONE = 3'h1;
  localparam logic [2:0] ITEMS_CIPHER = 3'h2;
  localparam logic [2:0] ITEMS_BURST = 3'h4;
  // Channel numbering
  localparam int EXT_LINES = 4;
  localparam int SER_CH_LO = 3;
  localparam int SER_CH_HI = 5;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_READ, ST_WRITE}
    dcrm_state_t;

  function automatic logic ser_capable(input int ch);
    return ch >= SER_CH_LO && ch <= SER_CH_HI;
  endfunction

  function automatic logic [CNT_W-1:0] size_bytes(input logic [1:0] f);
    if (f == SZ_WORD)
      return BYTES_4;
    if (f == SZ_HALF)
      return BYTES_2;
    return BYTES_1;
  endfunction

  function automatic logic [31:0] step_ptr(input logic [31:0] p,
    input logic [1:0] st, input logic [CNT_W-1:0] b);
    if (st == STEP_INC)
      return p + 32'(b);
    if (st == STEP_DEC)
      return p - 32'(b);
    return p;
  endfunction
endpackage

/* verilog/dcrm_sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module dcrm_sync2
  import dcrm_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin levels in, synchronised out
  input wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dcrm_sync_t;

  dcrm_sync_t s;
  dcrm_sync_t next_s;

  always_comb
  begin
    next_s.meta = d;
    next_s.sync = s.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.sync;
endmodule
`default_nettype wire

/* verilog/dcrm_reqsel.sv */
`timescale 1ns/100ps
`default_nettype none
module dcrm_reqsel
  import dcrm_pkg::*;
#(
  parameter int CHAN_IDX = 0
)
(
  // Mode of the channel
  input wire logic [2:0] mode,
  // Request sources
  input wire logic [EXT_LINES-1:0] ext_req,
  input wire logic serial_tx_req,
  input wire logic serial_rx_req,
  input wire logic cipher_in_req,
  input wire logic cipher_out_req,
  // Selected request
  output logic req,
  output logic is_ext
);
  localparam int LINE =
    (CHAN_IDX >= EXT_LINES) ? CHAN_IDX - EXT_LINES : CHAN_IDX;
  localparam logic SER_OK = ser_capable(CHAN_IDX);

  always_comb
  begin
    req = 1'b0;
    is_ext = 1'b0;
    case (mode)
      MODE_SOFT:
        req = 1'b1;
      MODE_EXT:
      begin
        req = ext_req[LINE];
        is_ext = 1'b1;
      end
      MODE_SER_TX:
        req = SER_OK && serial_tx_req;
      MODE_SER_RX:
        req = SER_OK && serial_rx_req;
      MODE_CIP_IN:
        req = cipher_in_req;
      MODE_CIP_OUT:
        req = cipher_out_req;
      default:
        req = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* verilog/dcrm_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module dcrm_channel
  import dcrm_pkg::*;
#(
  parameter int CHAN_IDX = 0
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic pready,
  output wire logic pslverr,
  // External request pins
  input wire logic [EXT_LINES-1:0] ext_dma_request,
  output wire logic ext_dma_acknowledge,
  // Internal request lines
  input wire logic serial_tx_req,
  input wire logic serial_rx_req,
  input wire logic cipher_in_req,
  input wire logic cipher_out_req,
  // Transfer port
  output wire logic acc_req,
  output wire logic acc_we,
  output wire logic [1:0] acc_tgt,
  output wire logic [1:0] acc_size,
  output wire logic [31:0] acc_addr,
  output wire logic [31:0] acc_wdata,
  input wire logic [31:0] acc_rdata,
  input wire logic acc_ack
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] src;
    logic [31:0] dst;
    logic [CNT_W-1:0] cnt;
    logic pend;
    dcrm_state_t st;
    logic [2:0] glen;
    logic [1:0] idx;
    logic [2:0] left;
    logic armed;
    logic ack;
    logic [3:0] ack_cnt;
    logic [3:0][31:0] hold;
    logic acc_req;
    logic acc_we;
    logic [1:0] acc_tgt;
    logic [1:0] acc_size;
    logic [31:0] acc_addr;
    logic [31:0] acc_wdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } dcrm_regs_t;

  dcrm_regs_t s;
  dcrm_regs_t next_s;
  logic [EXT_LINES-1:0] ext_sync;
  logic req;
  logic is_ext;
  logic [2:0] mode;
  logic blk;
  logic burst;
  logic ser;
  logic cip;
  logic src_mem;
  logic dst_mem;
  logic [1:0] tgt;
  logic [1:0] size;
  logic [CNT_W-1:0] sz;
  logic [CNT_W-1:0] cnt_dec;
  logic [2:0] items;
  logic take;
  logic done_acc;
  logic lastw;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] rdval;

  dcrm_sync2 #(
    .W(EXT_LINES)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(ext_dma_request),
    .q(ext_sync)
  );

  dcrm_reqsel #(
    .CHAN_IDX(CHAN_IDX)
  ) u_reqsel (
    .mode(mode),
    .ext_req(ext_sync),
    .serial_tx_req(serial_tx_req),
    .serial_rx_req(serial_rx_req),
    .cipher_in_req(cipher_in_req),
    .cipher_out_req(cipher_out_req),
    .req(req),
    .is_ext(is_ext)
  );

  assign mode = s.ctrl[CTL_MODE_LO +: 3];
  assign blk = s.ctrl[CTL_BLOCK];
  assign burst = s.ctrl[CTL_BURST];
  assign size = s.ctrl[CTL_SIZE_LO +: 2];
  assign ser = mode == MODE_SER_TX || mode == MODE_SER_RX;
  assign cip = mode == MODE_CIP_IN || mode == MODE_CIP_OUT;
  assign src_mem = !(mode == MODE_SER_RX || mode == MODE_CIP_OUT);
  assign dst_mem = !(mode == MODE_SER_TX || mode == MODE_CIP_IN);
  assign tgt = ser ? TGT_SER : (cip ? TGT_CIP : TGT_MEM);
  assign sz = size_bytes(size);
  assign cnt_dec = (s.cnt < sz) ? '0 : s.cnt - sz;
  assign items = ser ? ITEMS_ONE :
    (burst ? ITEMS_BURST : (cip ? ITEMS_CIPHER : ITEMS_ONE));
  assign take = s.st == ST_WAIT && s.ctrl[CTL_RUN] && s.cnt != '0 &&
    req && (!is_ext || s.armed);
  assign done_acc = s.acc_req && acc_ack;
  assign lastw = {1'b0, s.idx} == s.glen - ITEMS_ONE;
  assign wr = psel && penable && pwrite && s.pready;
  assign rd = psel && penable && !s.pready;

  function automatic logic [2:0] grp_len(input logic [CNT_W-1:0] c);
    if (burst && !ser && c >= (sz << 2))
      return ITEMS_BURST;
    return ITEMS_ONE;
  endfunction

  function automatic dcrm_regs_t finish(input dcrm_regs_t r);
    r.ctrl[CTL_RUN] = 1'b0;
    r.st = ST_IDLE;
    if (r.ctrl[CTL_IE])
      r.pend = 1'b1;
    return r;
  endfunction

  always_comb
  begin
    hit = 1'b1;
    rdval = '0;
    case (paddr)
      OFF_CTRL:
        rdval = {s.st != ST_IDLE, {(CTL_BUSY - CTRL_W){1'b0}}, s.ctrl};
      OFF_SRC:
        rdval = s.src;
      OFF_DST:
        rdval = s.dst;
      OFF_CNT:
        rdval = 32'(s.cnt);
      OFF_RUN:
        rdval = '0;
      OFF_PEND:
        rdval = 32'(s.pend);
      default:
        hit = 1'b0;
    endcase
  end

  always_comb
  begin
    next_s = s;
    // APB answer one cycle late
    next_s.pready = rd;
    if (rd)
    begin
      next_s.prdata = rdval;
      next_s.pslverr = !hit;
    end
    if (wr)
    begin
      case (paddr)
        OFF_CTRL:
          next_s.ctrl = pwdata[CTRL_W-1:0];
        OFF_SRC:
          next_s.src = pwdata;
        OFF_DST:
          next_s.dst = pwdata;
        OFF_CNT:
          next_s.cnt = pwdata[CNT_W-1:0];
        OFF_RUN:
          next_s.ctrl[CTL_RUN] = pwdata[CTL_RUN];
        OFF_PEND:
          if (pwdata[PEND_BIT])
            next_s.pend = 1'b0;
        default:
          ;
      endcase
    end
    // Acknowledge length count
    if (s.ack)
    begin
      if (s.ack_cnt == '0)
        next_s.ack = 1'b0;
      else
        next_s.ack_cnt = s.ack_cnt - 4'h1;
    end
    if (!req && !s.ack)
      next_s.armed = 1'b1;
    unique case (s.st)
      ST_IDLE:
        if (s.ctrl[CTL_RUN])
          next_s.st = ST_WAIT;
      ST_WAIT:
      begin
        if (!s.ctrl[CTL_RUN])
          next_s.st = ST_IDLE;
        else if (s.cnt == '0)
          next_s = finish(next_s);
        else if (take)
        begin
          next_s.left = items;
          next_s.glen = grp_len(s.cnt);
          next_s.idx = '0;
          next_s.st = ST_READ;
          if (is_ext)
          begin
            next_s.ack = 1'b1;
            next_s.ack_cnt = s.ctrl[CTL_ACK_LO +: 4];
            next_s.armed = 1'b0;
          end
        end
      end
      ST_READ:
        if (done_acc)
        begin
          next_s.hold[s.idx] = acc_rdata;
          if (src_mem)
            next_s.src = step_ptr(s.src, s.ctrl[CTL_SSTEP_LO +: 2], sz);
          next_s.idx = s.idx + 2'h1;
          if (lastw)
          begin
            next_s.idx = '0;
            next_s.st = ST_WRITE;
          end
        end
      ST_WRITE:
        if (done_acc)
        begin
          if (dst_mem)
            next_s.dst = step_ptr(s.dst, s.ctrl[CTL_DSTEP_LO +: 2], sz);
          next_s.cnt = cnt_dec;
          next_s.idx = s.idx + 2'h1;
          if (lastw)
          begin
            next_s.idx = '0;
            if (!blk)
              next_s.left = s.left - s.glen;
            if (cnt_dec == '0)
              next_s = finish(next_s);
            else if (blk || next_s.left != '0)
            begin
              next_s.glen = grp_len(cnt_dec);
              next_s.st = ST_READ;
            end
            else
              next_s.st = ST_WAIT;
          end
        end
    endcase
    next_s.acc_req = next_s.st == ST_READ || next_s.st == ST_WRITE;
    next_s.acc_we = next_s.st == ST_WRITE;
    next_s.acc_size = size;
    next_s.acc_wdata = next_s.hold[next_s.idx];
    if (next_s.st == ST_WRITE)
    begin
      next_s.acc_tgt = dst_mem ? TGT_MEM : tgt;
      next_s.acc_addr = dst_mem ? next_s.dst : '0;
    end
    else
    begin
      next_s.acc_tgt = src_mem ? TGT_MEM : tgt;
      next_s.acc_addr = src_mem ? next_s.src : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign ext_dma_acknowledge = s.ack;
  assign acc_req = s.acc_req;
  assign acc_we = s.acc_we;
  assign acc_tgt = s.acc_tgt;
  assign acc_size = s.acc_size;
  assign acc_addr = s.acc_addr;
  assign acc_wdata = s.acc_wdata;

  default clocking dcrm_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_last_write;
    s.st == ST_WRITE && done_acc && lastw;
  endsequence
  sequence seq_read_last;
    s.st == ST_READ && done_acc && lastw;
  endsequence

  chk_ser_chan: assert property (
    (s.st == ST_WAIT && ser && !ser_capable(CHAN_IDX)) |=> s.st != ST_READ)
    else $error("serial request served on wrong channel");
  chk_ser_tx: assert property (
    (s.st == ST_WRITE && mode == MODE_SER_TX) |-> acc_tgt == TGT_SER && acc_we)
    else $error("serial transmit write not to serial port");
  chk_ser_rx: assert property (
    (s.st == ST_READ && mode == MODE_SER_RX) |-> acc_tgt == TGT_SER && !acc_we)
    else $error("serial receive read not from serial port");
  chk_ser_byte: assert property (
    (take && ser) |=> s.left == ITEMS_ONE && s.glen == ITEMS_ONE)
    else $error("serial request not one item");
  chk_cip_words: assert property (
    (take && cip) |=> s.left == ($past(burst) ? ITEMS_BURST : ITEMS_CIPHER))
    else $error("cipher request item count wrong");
  chk_ptr_hold: assert property (
    (s.st == ST_WRITE && done_acc && !dst_mem && !wr) |=> $stable(s.dst))
    else $error("ignored destination pointer moved");
  chk_burst_rw: assert property (
    seq_read_last |=> s.st == ST_WRITE && acc_we && s.idx == '0)
    else $error("writes do not follow group reads");
  chk_end_idle: assert property (
    seq_last_write ##0 (cnt_dec == '0) |=> s.st == ST_IDLE && !s.ctrl[CTL_RUN])
    else $error("channel not idle at count zero");
  chk_pend_set: assert property (
    seq_last_write ##0 (cnt_dec == '0 && s.ctrl[CTL_IE]) |=> s.pend)
    else $error("pending flag not set at completion");
  chk_ext_ack: assert property (
    (take && is_ext) |=> ext_dma_acknowledge && !s.armed)
    else $error("no acknowledge after external request");
  chk_cnt_step: assert property (
    (s.st == ST_WRITE && done_acc) |=> s.cnt == $past(cnt_dec))
    else $error("count step differs from item size");
  chk_single_wait: assert property (
    seq_last_write ##0 (!blk && cnt_dec != '0 && s.left == s.glen)
    |=> s.st == ST_WAIT)
    else $error("single mode did not wait for request");
  chk_block_run: assert property (
    seq_last_write ##0 (blk && cnt_dec != '0) |=> s.st == ST_READ)
    else $error("block mode stopped before count zero");
  chk_grp_len: assert property (
    (take && s.cnt < (sz << 2)) |=> s.glen == ITEMS_ONE)
    else $error("short remainder moved as burst");
endmodule
`default_nettype wire

/* verif/dcrm_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dcrm_far_model
  import dcrm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Answer delay in cycles
  input wire logic [3:0] lag,
  // Transfer port
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [1:0] acc_tgt,
  input wire logic [31:0] acc_addr,
  output logic [31:0] acc_rdata,
  output logic acc_ack
);
  logic [3:0] wcnt;
  logic [31:0] cyc;
  logic [31:0] val;
  // memory, serial port or cipher answers
  always_comb
  begin
    val = acc_addr ^ 32'h5A5A0000;
    if (acc_tgt == TGT_SER)
      val = 32'h000000C3;
    if (acc_tgt == TGT_CIP)
      val = 32'h1234ABCD;
    acc_ack = acc_req && (wcnt >= lag);
    // Read data only valid while answering
    acc_rdata = (acc_ack && !acc_we) ? val : cyc;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wcnt <= 4'h0;
      cyc <= 32'h0;
    end
    else
    begin
      cyc <= ~cyc + 32'h1;
      wcnt <= (!acc_req || acc_ack) ? 4'h0 : wcnt + 4'h1;
    end
endmodule
`default_nettype wire

/* verif/dma_channel_request_modes_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module dma_channel_request_modes_tb
  import dcrm_pkg::*;
  ;
  typedef struct {logic [2:0] md; logic blk; logic bst; logic [1:0] sz;
    logic ie; logic [3:0] ackf; logic [23:0] cnt; int n1; int nt;
    logic [1:0] rt; logic [1:0] wt;} dcrm_row_t;
  typedef struct {logic we; logic [1:0] tgt; logic [31:0] addr;
    logic [31:0] wd; logic [31:0] rd; logic [1:0] sz;} dcrm_acc_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_ack;
  logic acc_req, acc_we, acc_ack, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, acc_addr, acc_wdata, acc_rdata, rdv, ctl, src;
  logic [3:0] ext_req, ireq, lag;
  logic [1:0] acc_tgt, acc_size;
  int fail_count, compares, b, j;
  dcrm_acc_t log_q[$];
  dcrm_acc_t e0, ew;
  dcrm_row_t r;
  dcrm_row_t rows[9] = '{
    '{MODE_SOFT, 0, 0, SZ_WORD, 1, 0, 24'd8, 4, 4, TGT_MEM, TGT_MEM},
    '{MODE_EXT, 0, 0, 2'h0, 0, 3, 24'd3, 2, 6, TGT_MEM, TGT_MEM},
    '{MODE_EXT, 0, 1, SZ_WORD, 1, 0, 24'd20, 8, 10, TGT_MEM, TGT_MEM},
    '{MODE_EXT, 1, 0, 2'h0, 0, 1, 24'd5, 10, 10, TGT_MEM, TGT_MEM},
    '{MODE_EXT, 1, 1, SZ_HALF, 1, 0, 24'd10, 10, 10, TGT_MEM, TGT_MEM},
    '{MODE_SER_TX, 0, 0, 2'h0, 1, 0, 24'd2, 2, 4, TGT_MEM, TGT_SER},
    '{MODE_SER_RX, 0, 0, 2'h0, 0, 0, 24'd2, 2, 4, TGT_SER, TGT_MEM},
    '{MODE_CIP_IN, 0, 0, SZ_WORD, 1, 0, 24'd16, 4, 8, TGT_MEM, TGT_CIP},
    '{MODE_CIP_OUT, 0, 1, SZ_WORD, 0, 0, 24'd24, 8, 12, TGT_CIP, TGT_MEM}};

  dcrm_channel #(.CHAN_IDX(4)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_dma_request(ext_req), .ext_dma_acknowledge(ext_ack),
    .serial_tx_req(ireq[0]), .serial_rx_req(ireq[1]),
    .cipher_in_req(ireq[2]), .cipher_out_req(ireq[3]), .acc_req(acc_req),
    .acc_we(acc_we), .acc_tgt(acc_tgt), .acc_size(acc_size),
    .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack));
  dcrm_far_model far (.pclk(pclk), .presetn(presetn), .lag(lag),
    .acc_req(acc_req), .acc_we(acc_we), .acc_tgt(acc_tgt),
    .acc_addr(acc_addr), .acc_rdata(acc_rdata), .acc_ack(acc_ack));

  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    $display("[FAIL] wait expected handshake seen timeout");
    summarize();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
      tmo();
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fire(input dcrm_row_t x);
    int n;
    n = 0;
    @(posedge pclk);
    if (x.md == MODE_EXT)
    begin
      ext_req[0] <= 1'b1;
      while (ext_ack !== 1'b1 && n < 60)
      begin
        @(negedge pclk);
        n++;
      end
      if (ext_ack !== 1'b1)
        tmo();
      @(posedge pclk);
      ext_req[0] <= 1'b0;
      n = 1;
      @(negedge pclk);
      while (ext_ack === 1'b1 && n < 40)
      begin
        n++;
        @(negedge pclk);
      end
      chk("ack_cycles", 32'(x.ackf) + 32'h1, 32'(n));
    end
    else if (x.md != MODE_SOFT)
    begin
      ireq[x.md - 3'h2] <= 1'b1;
      while (acc_req !== 1'b1 && n < 60)
      begin
        @(negedge pclk);
        n++;
      end
      if (acc_req !== 1'b1)
        tmo();
      @(posedge pclk);
      ireq <= 4'h0;
    end
  endtask
  task automatic settle();
    int n, q;
    n = 0;
    q = 0;
    while (acc_req !== 1'b1 && n < 40)
    begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (q < 4 && n < 600)
    begin
      @(negedge pclk);
      q = (acc_req === 1'b1) ? 0 : q + 1;
      n++;
    end
    if (n >= 600)
      tmo();
  endtask

  always @(negedge pclk)
    if (acc_req === 1'b1 && acc_ack === 1'b1)
      log_q.push_back(dcrm_acc_t'{acc_we, acc_tgt, acc_addr, acc_wdata,
        acc_rdata, acc_size});
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    repeat (100000) @(posedge pclk);
    tmo();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_req, ireq, lag} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, rdv);
    for (int i = 0; i < 9; i++)
    begin
      r = rows[i];
      ctl = 32'h0;
      ctl[CTL_MODE_LO +: 3] = r.md;
      ctl[CTL_BLOCK] = r.blk;
      ctl[CTL_BURST] = r.bst;
      ctl[CTL_SIZE_LO +: 2] = r.sz;
      ctl[CTL_IE] = r.ie;
      ctl[CTL_ACK_LO +: 4] = r.ackf;
      src = 32'h00001000 + 32'(i << 5);
      lag <= (i % 2 == 1) ? 4'h2 : 4'h0;
      // size, count and block as software must set them
      apb(1'b1, OFF_CTRL, ctl);
      apb(1'b1, OFF_SRC, src);
      apb(1'b1, OFF_DST, 32'h00008000);
      apb(1'b1, OFF_CNT, 32'(r.cnt));
      b = log_q.size();
      apb(1'b1, OFF_RUN, 32'h1);
      fire(r);
      settle();
      chk("first_request", 32'(r.n1), 32'(log_q.size() - b));
      apb(1'b0, OFF_CNT, 32'h0);
      j = 0;
      while (rdv !== 32'h0 && j < 20)
      begin
        fire(r);
        settle();
        apb(1'b0, OFF_CNT, 32'h0);
        j++;
      end
      if (rdv !== 32'h0)
        tmo();
      chk("total", 32'(r.nt), 32'(log_q.size() - b));
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("run_busy", 32'h0, {rdv[CTL_BUSY], rdv[CTL_RUN]});
      apb(1'b0, OFF_PEND, 32'h0);
      chk("pending", 32'(r.ie), rdv);
      apb(1'b1, OFF_PEND, 32'h1);
      apb(1'b0, OFF_PEND, 32'h0);
      chk("pending_clear", 32'h0, rdv);
      if (log_q.size() >= b + 4)
      begin
        e0 = log_q[b];
        ew = log_q[(r.bst && r.n1 >= 8) ? b + 4 : b + 1];
        chk("read_order", 32'h0,
          32'(log_q[(r.bst && r.n1 >= 8) ? b + 3 : b + 2].we));
        chk("write_order", 32'h1, 32'(ew.we));
        chk("read_target", 32'(r.rt), 32'(e0.tgt));
        chk("write_target", 32'(r.wt), 32'(ew.tgt));
        chk("read_addr", (r.rt == TGT_MEM) ? src : 32'h0, e0.addr);
        chk("write_addr", (r.wt == TGT_MEM) ? 32'h8000 : 32'h0, ew.addr);
        chk("moved_data", e0.rd, ew.wd);
        chk("item_size", 32'(r.sz), 32'(ew.sz));
      end
      $display("row %0d done", i);
    end
    b = log_q.size();
    @(posedge pclk);
    ireq[3] <= 1'b1;
    repeat (10) @(posedge pclk);
    ireq[3] <= 1'b0;
    chk("idle_after_done", 32'(b), 32'(log_q.size()));
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_data", 32'h0, rdv);
    $display("idle and unmapped done");
    apb(1'b1, OFF_CTRL, 32'h00000080);
    apb(1'b1, OFF_CNT, 32'h00000040);
    apb(1'b1, OFF_RUN, 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("reset_acc_req", 32'h0, 32'(acc_req));
    presetn <= 1'b1;
    apb(1'b0, OFF_CNT, 32'h0);
    chk("reset_count", 32'h0, rdv);
    $display("mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
